/* File: include/psw_consts.vh */
// Functional notes
// - Pending read returns serialized or pending value.
// - Separate readers choose candidates independently.
// - Repeated samples in one read choose independently.
// - 64-bit word with four overlapping sections.
// - User mask OR, AND-NOT, move at any level.
// - User mask updates visible without serialization.
// - System mask OR or AND-NOT, privileged.
// - Lower-half move replaces bits 31..0.
// - Full read returns 36..35 and 31..0 only.
// - Other high bits visible only via saved copy.
// - Return loads all bits, serializes implicitly.
// - Full read and return need level 0.
// - Privileged op at nonzero level raises fault.
// - Float-written flags sticky until user mask write.
`ifndef PSW_CONSTS_VH
`define PSW_CONSTS_VH
`define PSW_WIDTH 64
`define PSW_UM_MSB 5
`define PSW_SM_MSB 23
`define PSW_LO_MSB 31
`define PSW_MFL_BIT 4
`define PSW_MFH_BIT 5
`define PSW_CPL_LSB 32
`define PSW_CPL_MSB 33
`define PSW_RESET 64'h0000_0000_0000_0000
`define PSW_WR_MASK 64'h0000_3fff_0ffe_e03e
`define PSW_RD_MASK 64'h0000_0018_ffff_ffff
`define PSW_OP_NONE 4'h0
`define PSW_OP_SUM 4'h1
`define PSW_OP_RUM 4'h2
`define PSW_OP_MOVUM 4'h3
`define PSW_OP_RDUM 4'h4
`define PSW_OP_SSM 4'h5
`define PSW_OP_RSM 4'h6
`define PSW_OP_MOVL 4'h7
`define PSW_OP_RDPSR 4'h8
`define PSW_OP_RFI 4'h9
`define PSW_OP_SRLZ 4'ha
`endif

/* File: rtl/psw_pick.v */
`timescale 1ns/1ps
// Picks one candidate among the serialized and pending values.
module psw_pick #(
   parameter WIDTH = 64
) (
   candA,
   candB,
   candValid,
   sel,
   picked
);
   input wire [WIDTH-1:0] candA;
   input wire [WIDTH-1:0] candB;
   input wire candValid;
   input wire sel;
   output wire [WIDTH-1:0] picked;
   assign picked = (candValid && sel) ? candB : candA;
endmodule // psw_pick

/* File: rtl/psw_status_word.v */
`timescale 1ns/1ps
`include "psw_consts.vh"
module psw_status_word (
   sys_clk,
   rst_n,
   clkEn,
   opValid,
   opCode,
   opImm,
   opGr,
   savedStatus,
   fpLowWritten,
   fpHighWritten,
   opDone,
   privFault,
   readData,
   statusWord,
   pendingFlag
);
   input wire sys_clk;
   input wire rst_n;
   input wire clkEn;
   input wire opValid;
   input wire [3:0] opCode;
   input wire [23:0] opImm;
   input wire [63:0] opGr;
   input wire [63:0] savedStatus;
   input wire fpLowWritten;
   input wire fpHighWritten;
   output reg opDone;
   output reg privFault;
   output reg [63:0] readData;
   output wire [63:0] statusWord;
   output wire pendingFlag;

   ////////////////////////////////////////////////////////////////////////////
   reg rstMeta_r;
   reg rstSync_r;
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rstMeta_r <= 1'b0;
         rstSync_r <= 1'b0;
      end else begin
         rstMeta_r <= 1'b1;
         rstSync_r <= rstMeta_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // The serialized copy drives side effects; the pending copy holds the
   // newest unserialized write. Keeping only the newest pending value is a
   // trade-off: older pending values are never chosen, which is allowed.
   reg [63:0] serial_r;
   reg [63:0] pend_r;
   reg pendValid_r;
   reg [1:0] lfsr_r;
   reg [63:0] serial_nxt;
   reg [63:0] pend_nxt;
   reg pendValid_nxt;
   reg [63:0] cur;
   reg [63:0] base;
   reg [23:0] umMix;
   reg [63:0] readNxt;
   wire [63:0] seen;
   wire [1:0] lfsr_nxt;
   wire [5:0] fpSet;
   wire isPriv;
   wire cplZero;
   wire opAllowed;
   wire umWrite;

   function [63:0] keepLegal;
      input [63:0] v;
      begin
         keepLegal = v & `PSW_WR_MASK;
      end
   endfunction

   // Set and clear share one form so the user and system mask paths cannot
   // drift apart.
   function [23:0] maskOp;
      input [23:0] old;
      input [23:0] imm;
      input clear;
      begin
         if (clear) begin
            maskOp = old & ~imm;
         end else begin
            maskOp = old | imm;
         end
      end
   endfunction

   function isPrivOp;
      input [3:0] code;
      begin
         isPrivOp = (code == `PSW_OP_SSM) || (code == `PSW_OP_RSM) ||
            (code == `PSW_OP_MOVL) || (code == `PSW_OP_RDPSR) || (code == `PSW_OP_RFI);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Privilege is judged on the serialized level alone. No pending write can
   // touch the level field, so the judgement is never stale.
   assign cplZero = (serial_r[`PSW_CPL_MSB:`PSW_CPL_LSB] == 2'h0);
   assign isPriv = isPrivOp(opCode);
   assign opAllowed = opValid && !(isPriv && !cplZero);
   assign umWrite = opAllowed && ((opCode == `PSW_OP_SUM) || (opCode == `PSW_OP_RUM) ||
      (opCode == `PSW_OP_MOVUM));
   assign fpSet = {fpHighWritten, fpLowWritten, 4'h0};
   assign lfsr_nxt = {lfsr_r[0] ^ lfsr_r[1], lfsr_r[1]};
   assign statusWord = serial_r;
   assign pendingFlag = pendValid_r;

   // A fresh random bit per enabled cycle makes each reader and each sample independent.
   psw_pick #(.WIDTH(`PSW_WIDTH)) pickU (
      .candA(serial_r),
      .candB(pend_r),
      .candValid(pendValid_r),
      .sel(lfsr_r[0]),
      .picked(seen)
   );

   always @* begin
      serial_nxt = serial_r;
      pend_nxt = pend_r;
      pendValid_nxt = pendValid_r;
      cur = pendValid_r ? pend_r : serial_r;
      base = cur;
      umMix = 24'h0;
      if (opAllowed) begin
         case (opCode)
            `PSW_OP_SUM, `PSW_OP_RUM: begin
               umMix = maskOp({18'h0, serial_r[`PSW_UM_MSB:0]}, {18'h0, opImm[`PSW_UM_MSB:0]},
                  opCode == `PSW_OP_RUM);
               serial_nxt = keepLegal({serial_r[63:6], umMix[`PSW_UM_MSB:0]});
            end
            `PSW_OP_MOVUM: begin
               serial_nxt = keepLegal({serial_r[63:6], opGr[`PSW_UM_MSB:0]});
            end
            `PSW_OP_SSM, `PSW_OP_RSM: begin
               base[`PSW_SM_MSB:0] = maskOp(cur[`PSW_SM_MSB:0], opImm,
                  opCode == `PSW_OP_RSM);
               pend_nxt = keepLegal(base);
               pendValid_nxt = 1'b1;
            end
            `PSW_OP_MOVL: begin
               base[`PSW_LO_MSB:0] = opGr[31:0];
               pend_nxt = keepLegal(base);
               pendValid_nxt = 1'b1;
            end
            `PSW_OP_RFI: begin
               serial_nxt = keepLegal(savedStatus);
               pendValid_nxt = 1'b0;
            end
            `PSW_OP_SRLZ: begin
               if (pendValid_r) begin
                  serial_nxt = pend_r;
               end
               pendValid_nxt = 1'b0;
            end
            default: begin
               pendValid_nxt = pendValid_r;
            end
         endcase
      end
      // User mask writes land in the serialized copy; keep the pending copy
      // in step so a later serialize does not roll them back.
      if (umWrite) begin
         pend_nxt[`PSW_UM_MSB:0] = serial_nxt[`PSW_UM_MSB:0];
      end
      // Flag sets come last so that a set wins over a same-cycle mask write.
      serial_nxt[`PSW_UM_MSB:0] = serial_nxt[`PSW_UM_MSB:0] | fpSet;
      pend_nxt[`PSW_UM_MSB:0] = pend_nxt[`PSW_UM_MSB:0] | fpSet;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read data is formed apart from the state update so that a hidden bit can
   // never leak through a stale path; everything outside the readable set is zero.
   always @* begin
      readNxt = 64'h0;
      if (opAllowed && (opCode == `PSW_OP_RDUM)) begin
         readNxt = {58'h0, seen[`PSW_UM_MSB:0]};
      end else if (opAllowed && (opCode == `PSW_OP_RDPSR)) begin
         readNxt = seen & `PSW_RD_MASK;
      end
   end

   always @(posedge sys_clk or negedge rstSync_r) begin
      if (!rstSync_r) begin
         serial_r <= `PSW_RESET;
         pend_r <= `PSW_RESET;
         pendValid_r <= 1'b0;
      end else if (clkEn) begin
         serial_r <= serial_nxt;
         pend_r <= pend_nxt;
         pendValid_r <= pendValid_nxt;
      end
   end

   // The chooser steps only with the clock enable, so a frozen core also
   // freezes which candidate the next read will see.
   always @(posedge sys_clk or negedge rstSync_r) begin
      if (!rstSync_r) begin
         lfsr_r <= 2'h1;
      end else if (clkEn) begin
         lfsr_r <= lfsr_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always @(posedge sys_clk or negedge rstSync_r) begin
      if (!rstSync_r) begin
         opDone <= 1'b0;
         privFault <= 1'b0;
         readData <= 64'h0;
      end else if (clkEn) begin
         opDone <= opValid;
         privFault <= opValid && isPriv && !cplZero;
         readData <= readNxt;
      end
   end
endmodule // psw_status_word

/* File: sim/psw_pipe_model.sv */
`timescale 1ns/1ps
module psw_pipe_model (
   input wire logic sys_clk,
   output logic opValid = 1'h0,
   output logic [3:0] opCode = 4'h0,
   output logic [23:0] opImm = 24'h0,
   output logic [63:0] opGr = 64'h0,
   output logic [63:0] savedStatus = 64'h0
);
   // The opGr copy of the source data is inverted once released so that a stale value is never mistaken for a live one; savedStatus keeps it.
   task issue(input logic [3:0] c, input logic [23:0] i, input logic [63:0] g);
      @(negedge sys_clk);
      opValid = 1'h1;
      opCode = c;
      opImm = i;
      opGr = g;
      savedStatus = g;
      @(negedge sys_clk);
      opValid = 1'h0;
      opGr = ~g;
   endtask
endmodule // psw_pipe_model

/* File: sim/psw_sw_asserts.sv */
`timescale 1ns/1ps
`include "psw_consts.vh"
module psw_sw_asserts (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic clkEn,
   input wire logic opValid,
   input wire logic [3:0] opCode,
   input wire logic [23:0] opImm,
   input wire logic [63:0] savedStatus,
   input wire logic fpLowWritten,
   input wire logic fpHighWritten,
   input wire logic opDone,
   input wire logic privFault,
   input wire logic [63:0] readData,
   input wire logic [63:0] statusWord,
   input wire logic pendingFlag
);
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);
   wire go = clkEn & opValid;
   wire lvl0 = statusWord[33:32] == 2'h0;
   wire priv = opCode > 4'h4 && opCode < 4'ha;
   AST_DONE: assert property (go |=> opDone) else $error("no done");
   AST_RDMASK: assert property (opDone |-> (readData & ~`PSW_RD_MASK) == 64'h0)
      else $error("hidden bits read");
   AST_RSV: assert property ((statusWord & ~`PSW_WR_MASK) == 64'h0)
      else $error("reserved bit set");
   AST_FLT: assert property (go && priv && !lvl0 |=> privFault && $stable(statusWord[63:6]))
      else $error("no fault");
   AST_NOFLT: assert property (go && (lvl0 || !priv) |=> !privFault)
      else $error("bad fault");
   AST_SUM: assert property (go && opCode == 4'h1 |=>
      statusWord[5:0] == ((($past(statusWord[5:0]) | $past(opImm[5:0])) & 6'h3e) |
      {$past(fpHighWritten), $past(fpLowWritten), 4'h0}))
      else $error("user mask or");
   AST_PEND: assert property (go && lvl0 && opCode inside {4'h5, 4'h6, 4'h7} |=> pendingFlag)
      else $error("no pending");
   AST_SRLZ: assert property (go && opCode == 4'ha |=> !pendingFlag)
      else $error("still pending");
   AST_RFI: assert property (go && lvl0 && opCode == 4'h9 |=>
      statusWord == (($past(savedStatus) & `PSW_WR_MASK) |
      {58'h0, $past(fpHighWritten), $past(fpLowWritten), 4'h0}) && !pendingFlag)
      else $error("return load");
   AST_FREEZE: assert property (!clkEn |=>
      $stable(statusWord) && $stable(pendingFlag) && $stable(readData) && $stable(opDone))
      else $error("state moved while frozen");
   cover property (go && opCode == 4'h9);
   cover property (go && priv && !lvl0);
   cover property (go && opCode == 4'h8 && pendingFlag);
endmodule // psw_sw_asserts
bind psw_status_word psw_sw_asserts chk_i (.*);

/* File: sim/tb.sv */
`timescale 1ns/1ps
module tb;
   logic sys_clk = 1'h0;
   logic rst_n = 1'h0;
   logic clkEn = 1'h1;
   logic fpLowWritten = 1'h0;
   logic fpHighWritten = 1'h0;
   logic opValid, opDone, privFault, pendingFlag;
   logic [3:0] opCode;
   logic [23:0] opImm;
   logic [63:0] opGr, savedStatus, readData, statusWord;
   int n_mismatch = 0;
   int tests_run = 0;
   // Columns: code, immediate, source, expected word or read value, fault.
   logic [156:0] rows [16] = '{
      {4'h1, 24'h3f, 64'h0, 64'h3e, 1'h0}, {4'h2, 24'hc, 64'h0, 64'h32, 1'h0},
      {4'h3, 24'h0, 64'hffc5, 64'h4, 1'h0}, {4'h4, 24'h0, 64'h0, 64'h4, 1'h0},
      {4'h5, 24'hffffff, 64'h0, 64'h4, 1'h0}, {4'ha, 24'h0, 64'h0, 64'hfee03e, 1'h0},
      {4'h6, 24'he000, 64'h0, 64'hfee03e, 1'h0}, {4'ha, 24'h0, 64'h0, 64'hfe003e, 1'h0},
      {4'h7, 24'h0, ~64'h0, 64'hfe003e, 1'h0}, {4'ha, 24'h0, 64'h0, 64'hffee03e, 1'h0},
      {4'h8, 24'h0, 64'h0, 64'hffee03e, 1'h0},
      {4'h9, 24'h0, ~64'h300000000, 64'h3ffc0ffee03e, 1'h0},
      {4'h8, 24'h0, 64'h0, 64'h180ffee03e, 1'h0}, {4'h9, 24'h0, ~64'h0, 64'h3fff0ffee03e, 1'h0},
      {4'h5, 24'h0, 64'h0, 64'h3fff0ffee03e, 1'h1}, {4'h2, 24'h3e, 64'h0, 64'h3fff0ffee000, 1'h0}
   };
   psw_pipe_model pm (.*);
   psw_status_word dut (.*);
   task chk(input logic [63:0] seen, input logic [63:0] want);
      tests_run++;
      if (seen !== want) begin
         n_mismatch++;
         $display("FAIL %0t seen %h want %h", $time, seen, want);
      end
   endtask
   task report_and_stop;
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial forever #50 sys_clk = ~sys_clk;
   initial begin
      #50us;
      n_mismatch++;
      report_and_stop;
   end
   initial begin
      repeat (16) @(negedge sys_clk);
      rst_n = 1'h1;
      repeat (3) @(negedge sys_clk);
      foreach (rows[i]) begin
         pm.issue(rows[i][156:153], rows[i][152:129], rows[i][128:65]);
         chk(opDone, 1'h1);
         chk(privFault, rows[i][0]);
         chk(opCode inside {4'h4, 4'h8} ? readData : statusWord, rows[i][64:1]);
      end
      rst_n = 1'h0;
      @(negedge sys_clk);
      chk(statusWord, 64'h0);
      rst_n = 1'h1;
      repeat (3) @(negedge sys_clk);
      pm.issue(4'h5, 24'hff00, 64'h0);
      chk(pendingFlag, 1'h1);
      repeat (2) begin
         pm.issue(4'h8, 24'h0, 64'h0);
         chk(readData === 64'h0 || readData === 64'he000, 1'h1);
      end
      pm.issue(4'ha, 24'h0, 64'h0);
      fpLowWritten = 1'h1;
      @(negedge sys_clk);
      fpLowWritten = 1'h0;
      pm.issue(4'h1, 24'h0, 64'h0);
      chk(statusWord, 64'he010);
      pm.issue(4'h3, 24'h0, 64'h0);
      chk(statusWord, 64'he000);
      fork
         pm.issue(4'h3, 24'h0, 64'h0);
         begin
            @(negedge sys_clk);
            fpHighWritten = 1'h1;
            @(negedge sys_clk);
            fpHighWritten = 1'h0;
         end
      join
      chk(statusWord, 64'he020);
      clkEn = 1'h0;
      pm.issue(4'h1, 24'h3e, 64'h0);
      chk(statusWord, 64'he020);
      clkEn = 1'h1;
      report_and_stop;
   end
endmodule // tb
